// File: common/sisc_pkg.sv
package sisc_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_CLKSEL = 8'h04;
	localparam logic [7:0] ADDR_STAT   = 8'h08;
	localparam logic [7:0] ADDR_PLL    = 8'h0c;

	// Control register fields
	localparam int CTRL_STOP       = 0;
	localparam int CTRL_PSM_L      = 1;
	localparam int CTRL_PSM_H      = 2;
	localparam int CTRL_NMI0_WMASK = 3;
	localparam int CTRL_NMI1_WMASK = 4;
	localparam int CTRL_INT_WMASK  = 5;
	localparam int CTRL_W     = 6;

	// Clock select register fields
	localparam int CS_LPIT    = 0;
	localparam int CS_WT_SUB  = 2;
	localparam int CS_WDT     = 3;
	localparam int CS_CSI     = 5;
	localparam int CS_UART0   = 11;
	localparam int CS_W       = 12;

	// Count clock encodings
	localparam logic [1:0] LPIT_OSC8 = 2'h1;
	localparam logic [1:0] LPIT_SUB  = 2'h2;
	localparam logic [1:0] WDT_OSC   = 2'h0;
	localparam logic [1:0] WDT_SUB   = 2'h1;

	// Values after reset
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [CS_W-1:0]   CS_RST   = 12'h000;
	localparam logic              PLL_RST  = 1'b0;

	// Subclock cycles from wake request to exit
	localparam logic [3:0] WAKE_CYC = 4'hc;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_IDLE,
		ST_WAKE
	} sisc_state_t;

	typedef struct packed {
		logic       cpu;
		logic       dma;
		logic       tmr;
		logic       romc;
		logic       crc;
		logic       i2c;
		logic       can;
		logic       abus;
		logic       intc;
		logic       key;
		logic       lpit;
		logic       wt;
		logic       wdt;
		logic [5:0] csi;
		logic [3:0] uart;
	} sisc_run_t;

	typedef struct packed {
		logic adc;
		logic dac;
		logic realtime_output_unit;
		logic port;
		logic data;
		logic extbus;
	} sisc_hold_t;

	localparam sisc_run_t  RUN_RST  = 23'h7fffff;
	localparam sisc_hold_t HOLD_RST = 6'h00;
endpackage

// File: rtl/sisc_top.sv
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module sisc_top (
	input  wire logic               ref_clk_in,
	input  wire logic               reset_in,
	input  wire logic               psel_in,
	input  wire logic               penable_in,
	input  wire logic               pwrite_in,
	input  wire logic [7:0]         paddr_in,
	input  wire logic [31:0]        pwdata_in,
	output logic      [31:0]        prdata_out,
	output logic                    pready_out,
	output logic                    pslverr_out,
	input  wire logic               on_subclock_in,
	input  wire logic               main_osc_run_in,
	input  wire logic [1:0]         nmi_req_in,
	input  wire logic               mask_req_in,
	input  wire logic [2:0]         mask_prio_in,
	input  wire logic               isr_active_in,
	input  wire logic [2:0]         isr_prio_in,
	input  wire logic               global_irq_enabled_in,
	output logic                    sub_idle_out,
	output logic                    wake_pulse_out,
	output logic                    ack_nmi_out,
	output logic                    ack_mask_out,
	output logic                    branch_out,
	output logic                    intc_detect_out,
	output logic                    pll_run_out,
	output sisc_pkg::sisc_run_t     run_out,
	output sisc_pkg::sisc_hold_t    hold_out
);

	sisc_pkg::sisc_state_t          state;
	sisc_pkg::sisc_state_t          next_state;
	logic [sisc_pkg::CTRL_W-1:0]    ctrl;
	logic [sisc_pkg::CS_W-1:0]      clksel;
	logic                           pll_control_reg;
	logic [3:0]                     cnt;
	logic                           src_nmi;
	logic [31:0]                    prdata;
	logic                           ack_nmi;
	logic                           ack_mask;
	logic                           branch_q;
	logic                           wake_pulse;
	logic                           pll_run;
	sisc_pkg::sisc_run_t            run_q;
	sisc_pkg::sisc_hold_t           hold_q;
	sisc_pkg::sisc_run_t            next_run;
	sisc_pkg::sisc_hold_t           next_hold;

	// Bus decode
	wire setup_ph   = psel_in & ~penable_in;
	wire access_ph  = psel_in & penable_in;
	wire wr         = access_ph & pwrite_in;
	wire sel_ctrl   = paddr_in == sisc_pkg::ADDR_CTRL;
	wire sel_clksel = paddr_in == sisc_pkg::ADDR_CLKSEL;
	wire sel_stat   = paddr_in == sisc_pkg::ADDR_STAT;
	wire sel_pll    = paddr_in == sisc_pkg::ADDR_PLL;
	wire hit        = sel_ctrl | sel_clksel | sel_stat | sel_pll;
	wire wr_ctrl    = wr & sel_ctrl;
	wire wr_clksel  = wr & sel_clksel;
	wire wr_pll     = wr & sel_pll;

	assign pready_out  = 1'b1;
	assign pslverr_out = access_ph & ~hit;

	// Field views
	wire nmi0_wake_mask     = ctrl[sisc_pkg::CTRL_NMI0_WMASK];
	wire nmi1_wake_mask     = ctrl[sisc_pkg::CTRL_NMI1_WMASK];
	wire maskable_wake_mask = ctrl[sisc_pkg::CTRL_INT_WMASK];

	// Count clock selection views
	wire [1:0] lpit_sel = clksel[sisc_pkg::CS_LPIT +: 2];
	wire wt_sub         = clksel[sisc_pkg::CS_WT_SUB];
	wire [1:0] wdt_sel  = clksel[sisc_pkg::CS_WDT +: 2];
	wire [5:0] csi_ext  = clksel[sisc_pkg::CS_CSI +: 6];
	wire uart0_ext      = clksel[sisc_pkg::CS_UART0];

	// Entry request from the written data
	wire save_mode_sel_lo = pwdata_in[sisc_pkg::CTRL_PSM_L];
	wire standby_stop_bit = pwdata_in[sisc_pkg::CTRL_STOP];
	wire mode_ok = ~save_mode_sel_lo;
	wire in_run  = state == sisc_pkg::ST_RUN;
	wire in_idle = state == sisc_pkg::ST_IDLE;
	wire in_wake = state == sisc_pkg::ST_WAKE;
	wire enter = wr_ctrl & standby_stop_bit & mode_ok
		& on_subclock_in & in_run;

	// Wake sources after masking
	wire wake_nmi0 = nmi_req_in[0] & ~nmi0_wake_mask;
	wire wake_nmi1 = nmi_req_in[1] & ~nmi1_wake_mask;
	wire wake_mask = mask_req_in & ~maskable_wake_mask;
	wire wake_nmi  = wake_nmi0 | wake_nmi1;
	wire wake_any  = wake_nmi | wake_mask;

	// Lower value means higher priority
	function automatic logic outranks(input logic [2:0] req,
		input logic [2:0] cur);
		return req < cur;
	endfunction

	// Priority against the routine in service
	wire hi_prio = ~isr_active_in
		| outranks(mask_prio_in, isr_prio_in);

	// Last count of the wake wait
	wire [3:0] wake_last = sisc_pkg::WAKE_CYC - 4'h1;
	wire wake_done = in_wake & (cnt == wake_last);

	// State sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			sisc_pkg::ST_RUN: begin
				if (enter) begin
					next_state = sisc_pkg::ST_IDLE;
				end
			end
			sisc_pkg::ST_IDLE: begin
				// Pending request leaves at once
				if (wake_any) begin
					next_state = sisc_pkg::ST_WAKE;
				end
			end
			sisc_pkg::ST_WAKE: begin
				if (wake_done) begin
					next_state = sisc_pkg::ST_RUN;
				end
			end
		endcase
	end

	wire idle = ~in_run;

	// True when a two-bit select holds either value
	function automatic logic sel_either(input logic [1:0] v,
		input logic [1:0] a, input logic [1:0] b);
		return (v == a) | (v == b);
	endfunction

	// Units that may run on in standby
	wire lpit_keep  = sel_either(lpit_sel, sisc_pkg::LPIT_OSC8,
		sisc_pkg::LPIT_SUB);
	wire wt_keep    = ~main_osc_run_in & wt_sub;
	wire wdt_keep   = sel_either(wdt_sel, sisc_pkg::WDT_OSC,
		sisc_pkg::WDT_SUB);
	wire uart0_keep = uart0_ext;

	// Unit clock enables while gated
	always_comb begin
		next_run      = sisc_pkg::RUN_RST;
		next_run.cpu  = ~idle;
		next_run.dma  = ~idle;
		next_run.tmr  = ~idle;
		next_run.romc = ~idle;
		next_run.crc  = ~idle;
		next_run.can  = ~idle;
		next_run.abus = ~idle;
		next_run.i2c  = ~idle;
		next_run.intc = ~idle;
		next_run.key  = 1'b1;
		next_run.lpit = ~idle | lpit_keep;
		next_run.wt   = ~idle | wt_keep;
		next_run.wdt  = ~idle | wdt_keep;
		next_run.csi  = {6{~idle}} | csi_ext;
		next_run.uart = {{3{~idle}}, ~idle | uart0_keep};
	end

	// Hold indications while gated
	always_comb begin
		next_hold        = sisc_pkg::HOLD_RST;
		next_hold.adc    = idle;
		next_hold.dac    = idle;
		next_hold.realtime_output_unit    = idle;
		next_hold.port   = idle;
		next_hold.data   = idle;
		next_hold.extbus = idle;
	end

	// Status word fields
	wire stat_idle = idle;
	wire stat_wake = in_wake;
	wire stat_nmi  = src_nmi;
	wire stat_pll  = pll_run;
	wire stat_sub  = on_subclock_in;

	// Read mux
	wire [31:0] stat_word = {27'h0000000, stat_sub,
		stat_pll, stat_nmi, stat_wake, stat_idle};
	wire [31:0] next_rdata =
		sel_ctrl   ? {26'h0000000, ctrl} :
		sel_clksel ? {20'h00000, clksel} :
		sel_stat   ? stat_word :
		sel_pll    ? {31'h00000000, pll_control_reg} :
		32'h00000000;

	// Exit decisions
	wire mask_wins    = ~src_nmi & mask_req_in;
	wire mask_may_ack = hi_prio & global_irq_enabled_in;
	wire do_ack_nmi   = wake_done & src_nmi;
	wire do_ack_mask  = wake_done & mask_wins & mask_may_ack;

	// State, reset returns to normal run
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state <= sisc_pkg::ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Wake latency counter
	wire cnt_clear = reset_in | ~in_wake;
	always_ff @(posedge ref_clk_in) begin
		if (cnt_clear) begin
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end

	// Wake source latch
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			src_nmi <= 1'b0;
		end else if (in_idle && wake_any) begin
			src_nmi <= wake_nmi;
		end
	end

	// Control register, stop bit not stored
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ctrl <= sisc_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl <= {pwdata_in[sisc_pkg::CTRL_W-1:1], 1'b0};
		end
	end

	// Count clock selections
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			clksel <= sisc_pkg::CS_RST;
		end else if (wr_clksel) begin
			clksel <= pwdata_in[sisc_pkg::CS_W-1:0];
		end
	end

	// PLL enable, untouched by standby
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pll_control_reg <= sisc_pkg::PLL_RST;
		end else if (wr_pll) begin
			pll_control_reg <= pwdata_in[0];
		end
	end

	// PLL runs only with main clock
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pll_run <= 1'b0;
		end else begin
			pll_run <= pll_control_reg & main_osc_run_in;
		end
	end

	// Read data captured in setup
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			prdata <= 32'h00000000;
		end else if (setup_ph) begin
			prdata <= next_rdata;
		end
	end

	// Next values of the exit pulses
	wire next_wake_pulse = wake_done;
	wire next_ack_nmi    = do_ack_nmi;
	wire next_ack_mask   = do_ack_mask;
	wire next_branch     = do_ack_nmi | do_ack_mask;

	// Exit pulse
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			wake_pulse <= 1'b0;
		end else begin
			wake_pulse <= next_wake_pulse;
		end
	end

	// NMI acknowledge pulse
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ack_nmi <= 1'b0;
		end else begin
			ack_nmi <= next_ack_nmi;
		end
	end

	// Maskable acknowledge pulse
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ack_mask <= 1'b0;
		end else begin
			ack_mask <= next_ack_mask;
		end
	end

	// Branch pulse
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			branch_q <= 1'b0;
		end else begin
			branch_q <= next_branch;
		end
	end

	// Unit clock gating outputs
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			run_q <= sisc_pkg::RUN_RST;
		end else begin
			run_q <= next_run;
		end
	end

	// Hold outputs
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			hold_q <= sisc_pkg::HOLD_RST;
		end else begin
			hold_q <= next_hold;
		end
	end

	assign prdata_out      = prdata;
	assign sub_idle_out    = idle;
	assign wake_pulse_out  = wake_pulse;
	assign ack_nmi_out     = ack_nmi;
	assign ack_mask_out    = ack_mask;
	assign branch_out      = branch_q;
	assign intc_detect_out = 1'b1;
	assign pll_run_out     = pll_run;
	assign run_out         = run_q;
	assign hold_out        = hold_q;

endmodule

// File: testbench/sisc_cpu_model.sv
`timescale 1ns/1ps
module sisc_cpu_model (
	input  wire logic       clk_in,
	input  wire logic [1:0] set_nmi_in,
	input  wire logic       set_mask_in,
	input  wire logic       clear_in,
	input  wire logic       ack_nmi_in,
	input  wire logic       ack_mask_in,
	output logic      [1:0] nmi_req_out,
	output logic            mask_req_out
);
	initial nmi_req_out = 2'h0;
	initial mask_req_out = 1'b0;
	// Requests held as levels until taken or withdrawn
	always @(posedge clk_in) begin
		if (clear_in || ack_nmi_in)
			nmi_req_out <= 2'h0;
		else
			nmi_req_out <= nmi_req_out | set_nmi_in;
		if (clear_in || ack_mask_in)
			mask_req_out <= 1'b0;
		else
			mask_req_out <= mask_req_out | set_mask_in;
	end
endmodule

// File: testbench/sisc_asserts.sv
`timescale 1ns/1ps
module sisc_asserts (
	input wire logic                 ref_clk_in,
	input wire logic                 reset_in,
	input wire logic [1:0]           nmi_req_in,
	input wire logic                 mask_req_in,
	input wire logic [2:0]           mask_prio_in,
	input wire logic                 isr_active_in,
	input wire logic [2:0]           isr_prio_in,
	input wire logic                 global_irq_enabled_in,
	input wire logic                 sub_idle_out,
	input wire logic                 wake_pulse_out,
	input wire logic                 ack_nmi_out,
	input wire logic                 ack_mask_out,
	input wire logic                 branch_out,
	input wire logic                 intc_detect_out,
	input wire sisc_pkg::sisc_run_t  run_out,
	input wire sisc_pkg::sisc_hold_t hold_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	wake_lat_a:
	assert property (wake_pulse_out |-> !sub_idle_out && $past(sub_idle_out)
		&& $past(sub_idle_out, 11)) else $error("wake timing wrong");
	nmi_ack_a:
	assert property (ack_nmi_out |-> wake_pulse_out && $past(nmi_req_in, 12)
		!= 2'h0) else $error("nmi ack wrong");
	mask_ack_a:
	assert property (ack_mask_out |-> !ack_nmi_out && $past(mask_req_in)
		&& $past(global_irq_enabled_in) && (!$past(isr_active_in)
		|| $past(mask_prio_in) < $past(isr_prio_in))) else $error("mask ack");
	branch_a:
	assert property (branch_out == (ack_nmi_out || ack_mask_out))
		else $error("branch wrong");
	detect_on_a:
	assert property (intc_detect_out) else $error("detect off");
	gate_off_a:
	assert property (sub_idle_out && $past(sub_idle_out) |-> !run_out.cpu
		&& !run_out.dma && !run_out.tmr && !run_out.romc && !run_out.crc
		&& !run_out.i2c && !run_out.can && !run_out.abus && run_out.key
		&& run_out.uart[3:1] == 3'h0) else $error("gating wrong");
	hold_on_a:
	assert property (sub_idle_out && $past(sub_idle_out) |-> &hold_out)
		else $error("hold wrong");
	restore_a:
	assert property (!sub_idle_out && !$past(sub_idle_out) |->
		run_out == sisc_pkg::RUN_RST && hold_out == sisc_pkg::HOLD_RST)
		else $error("restore wrong");
endmodule
bind sisc_top sisc_asserts u_sisc_asserts (.*);

// File: testbench/sisc_top_tb.sv
`timescale 1ns/1ps
module sisc_top_tb;
	logic clk, rst, psel, pen, pwr, onsub, mosc, mreq, isr, gie, smask, clr;
	logic rdy, serr, sidle, wk, an, am, br, det, pll, e;
	logic [7:0] pa;
	logic [31:0] pwd, prd, q, lfsr;
	logic [2:0] mp, ip;
	logic [1:0] nreq, snmi;
	sisc_pkg::sisc_run_t run;
	sisc_pkg::sisc_hold_t hold;
	int err_total, samples_checked, n, c;
	logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
	logic [31:0] re[5] = '{32'h0, 32'h0, 32'h10, 32'h0, 32'h0};
	logic [9:0] mt[4] = '{10'h156, 10'h1a7, 10'h00c, 10'h20f};
	sisc_top u_sisc_top (.ref_clk_in(clk), .reset_in(rst), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.prdata_out(prd), .pready_out(rdy), .pslverr_out(serr),
		.on_subclock_in(onsub), .main_osc_run_in(mosc), .nmi_req_in(nreq),
		.mask_req_in(mreq), .mask_prio_in(mp), .isr_active_in(isr),
		.isr_prio_in(ip), .global_irq_enabled_in(gie), .sub_idle_out(sidle),
		.wake_pulse_out(wk), .ack_nmi_out(an), .ack_mask_out(am),
		.branch_out(br), .intc_detect_out(det), .pll_run_out(pll),
		.run_out(run), .hold_out(hold));
	sisc_cpu_model u_sisc_cpu_model (.clk_in(clk), .set_nmi_in(snmi),
		.set_mask_in(smask), .clear_in(clr), .ack_nmi_in(an),
		.ack_mask_in(am), .nmi_req_out(nreq), .mask_req_out(mreq));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [12:0] exp_units(input logic [11:0] s,
		input logic m);
		return {s[1:0] == sisc_pkg::LPIT_OSC8 || s[1:0] == sisc_pkg::LPIT_SUB,
			!m && s[2], s[4:3] == sisc_pkg::WDT_OSC || s[4:3] == sisc_pkg::WDT_SUB,
			s[10:5], 3'h0, s[11]};
	endfunction
	task automatic cmp(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic conclude(input logic hang);
		if (hang)
			err_total++;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (rdy !== 1'b1)
			conclude(1'b1);
		q = prd;
		e = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic raise(input logic [1:0] nm, input logic mk, input logic cl);
		@(posedge clk);
		snmi <= nm;
		smask <= mk;
		clr <= cl;
		@(posedge clk);
		snmi <= 2'h0;
		smask <= 1'b0;
		clr <= 1'b0;
	endtask
	task automatic wake();
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (wk !== 1'b1 && c < 40);
		if (wk !== 1'b1)
			conclude(1'b1);
	endtask
	initial begin
		{psel, pen, pwr, pa, pwd, snmi, smask, clr, isr, ip, mp, gie} = '0;
		{onsub, mosc, rst} = 3'h7;
		lfsr = 32'h6cbd;
		err_total = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ra[i], 32'h0);
			cmp("rdata", re[i], q);
			cmp("slverr", i == 4, e);
		end
		$display("registers done");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, sisc_pkg::ADDR_CTRL, 32'h1 | i << 1 | 32'h8 << i[1]);
			@(negedge clk);
			cmp("enter", !i[0], sidle);
			if (!i[0]) begin
				raise(2'h1 << i[1], 1'b0, 1'b0);
				repeat (20) @(negedge clk);
				cmp("masked", 1'b1, sidle);
				raise(2'h2 >> i[1], 1'b0, 1'b0);
				wake();
				// One negedge before the sampling edge, one after exit
				cmp("latency", sisc_pkg::WAKE_CYC + 2, c);
				cmp("nmi_ack", 3'h7, {an, br, am == 1'b0});
			end
		end
		$display("nmi wake done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) {isr, ip, mp, gie} <= mt[i][8:1];
			if (mt[i][9])
				raise(2'h0, 1'b1, 1'b0);
			apb(1'b1, sisc_pkg::ADDR_CTRL, 32'h1);
			if (!mt[i][9])
				raise(2'h0, 1'b1, 1'b0);
			wake();
			cmp("mask_ack", {2{mt[i][0]}}, {am, br});
			@(negedge clk);
			cmp("pending", !mt[i][0], mreq);
			raise(2'h0, 1'b0, 1'b1);
		end
		$display("maskable wake done");
		repeat (3) begin
			lfsr = next_rand(lfsr);
			apb(1'b1, sisc_pkg::ADDR_PLL, {31'h0, lfsr[12]});
			@(posedge clk) mosc <= lfsr[12];
			apb(1'b1, sisc_pkg::ADDR_CLKSEL, {20'h0, lfsr[11:0]});
			apb(1'b1, sisc_pkg::ADDR_CTRL, 32'h1);
			repeat (3) @(negedge clk);
			cmp("units", exp_units(lfsr[11:0], lfsr[12]), {run.lpit, run.wt,
				run.wdt, run.csi, run.uart});
			cmp("pll_run", lfsr[12], pll);
			@(posedge clk) rst <= 1'b1;
			@(posedge clk) rst <= 1'b0;
			@(negedge clk);
			cmp("reset", {1'b0, sisc_pkg::RUN_RST}, {sidle, run});
			apb(1'b0, sisc_pkg::ADDR_CLKSEL, 32'h0);
			cmp("clksel", 32'h0, q);
		end
		$display("clock select done");
		conclude(1'b0);
	end
endmodule
